// ### src/szm_zero_mgmt.v
/*
 Scale zero management: automatic zero tracking, power-up and requested
 zero capture, timed zero supervision with alarm and validity outputs,
 APB register file and a level interrupt.
 Assumes gross weight in signed divisions and a motion flag arriving from
 logic on CLK_SYS; key, discrete input and serial 'Z' strobes arrive from
 pins or other domains and are synchronised here.
*/
// What this block does
// (R1) Within tracking band and no motion, step zero toward true centre.
// (R2) Outside tracking band, no automatic zero adjustment happens.
// (R3) After reset with power-up capture enabled, wait for stability then capture zero.
// (R4) Power-up capture has enable and separate upper and lower limits.
// (R5) Zero requests come from key, discrete input, fieldbus or serial 'Z'.
// (R6) Requested zero accepted within band around calibrated or initial zero.
// (R7) Supervision timer restarts whenever stable centre of zero is seen.
// (R8) First expiry asserts zero-request output, message, restarts timing.
// (R9) Second expiry drops zero-request 200 ms, reasserts it, restarts timing.
// (R10) Stable centre of zero while pending clears request and restarts timer.
// (R11) Third expiry pulses request low, blanks weight, alarms, clears valid.
// (R12) Invalid state held until stable centre of zero, then all restored.
// (R13) Key zero only when semi-automatic zero enabled and weight in band.
// (R14) Supervision disabled after reset; enabled only by configuration.
// (R15) Timeout and 200 ms drop are counts of system clock cycles.
`timescale 1ns/10ps
`default_nettype none
`include "szm_defines.vh"

module szm_zero_mgmt #(
   parameter WW = 24,
   parameter DROP_CYC = `SZM_DROP_CYC,
   parameter AZT_STEP_CYC = `SZM_AZT_STEP_CYC
) (
   input wire CLK_SYS,
   input wire RST,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output wire PREADY,
   output reg [31:0] PRDATA,
   output wire PSLVERR,
   input wire signed [WW-1:0] GROSS_RAW,
   input wire MOTION,
   input wire ZERO_KEY,
   input wire ZERO_DIN,
   input wire ZERO_SERIAL,
   input wire ZERO_FIELDBUS,
   output wire signed [WW-1:0] GROSS_ZEROED,
   output reg CENTER_ZERO,
   output reg ZERO_REQ_OUT,
   output reg ZERO_REQ_MSG,
   output reg SYS_ALARM_OUT,
   output reg DATA_VALID,
   output reg ZERO_NOT_CAPTURED,
   output reg WEIGHT_BLANK,
   output wire IRQ
);
   // Configuration registers
   reg [31:0] ctrl_r;
   reg [31:0] azt_band_r;
   reg [31:0] pu_hi_r;
   reg [31:0] pu_lo_r;
   reg [31:0] semi_band_r;
   reg [31:0] timeout_r;
   reg [31:0] cap_r;
   reg [`SZM_NEV-1:0] int_r;
   reg [`SZM_NEV-1:0] mask_r;
   reg [`SZM_NEV-1:0] ev;
   // Zero state
   reg signed [WW-1:0] zero_r;
   reg signed [WW-1:0] init_zero_r;
   reg pu_pend_r;
   reg [31:0] azt_cnt_r;
   // Supervision
   reg [2:0] st_r;
   reg [31:0] tmr_r;
   reg [31:0] drop_r;
   // Synchronisers for the external request strobes
   reg [2:0] key_s_r;
   reg [2:0] din_s_r;
   reg [2:0] ser_s_r;
   reg [2:0] fb_s_r;

   wire wr = PSEL & PENABLE & PWRITE;
   wire rd_ok;
   wire signed [WW-1:0] net = GROSS_RAW - zero_r;
   wire [WW-1:0] net_abs = net[WW-1] ? -net : net;
   wire signed [WW-1:0] ref_zero = ctrl_r[`SZM_CTRL_PU_EN] ? init_zero_r : {WW{1'b0}};
   wire signed [WW-1:0] semi_dev = GROSS_RAW - ref_zero;
   wire [WW-1:0] semi_abs = semi_dev[WW-1] ? -semi_dev : semi_dev;
   wire [WW-1:0] azt_lim = azt_band_r[WW-1:0];
   // Percent bands scaled against capacity, widened so the product cannot wrap
   wire [47:0] semi_lim = ({16'h0000, cap_r} * {16'h0000, semi_band_r}) / 48'd100;
   wire [47:0] pu_hi_lim = ({16'h0000, cap_r} * {16'h0000, pu_hi_r}) / 48'd100;
   wire [47:0] pu_lo_lim = ({16'h0000, cap_r} * {16'h0000, pu_lo_r}) / 48'd100;
   wire stable_coz = CENTER_ZERO & ~MOTION;

   // Second and third stages both high mark a settled high level
   wire key_lvl = key_s_r[1] & key_s_r[2];
   wire din_lvl = din_s_r[1] & din_s_r[2];
   wire ser_lvl = ser_s_r[1] & ser_s_r[2];
   reg key_d_r, din_d_r, ser_d_r, fb_d_r;
   wire req_key = key_lvl & ~key_d_r;
   wire req_any = req_key | (din_lvl & ~din_d_r) | (ser_lvl & ~ser_d_r) |
      (fb_s_r[2] & ~fb_d_r) | (wr && PADDR == `SZM_CTRL_OFF && PWDATA[`SZM_CTRL_SW_ZERO]);
   wire semi_ok = ctrl_r[`SZM_CTRL_SEMI_EN] && ({24'h0, semi_abs} <= semi_lim) && !MOTION; // R6 R13
   wire pu_ok = !MOTION && (GROSS_RAW[WW-1] ? ({24'h0, -GROSS_RAW} <= pu_lo_lim)
      : ({24'h0, GROSS_RAW} <= pu_hi_lim)); // R4

   assign GROSS_ZEROED = net;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign IRQ = |(int_r & mask_r);

   // Input synchronisers; the fieldbus strobe is on-clock yet kept alike for simplicity
   always @(posedge CLK_SYS) begin
      if (RST) begin
         key_s_r <= 3'h0;
         din_s_r <= 3'h0;
         ser_s_r <= 3'h0;
         fb_s_r <= 3'h0;
         key_d_r <= 1'b0;
         din_d_r <= 1'b0;
         ser_d_r <= 1'b0;
         fb_d_r <= 1'b0;
      end else begin
         key_s_r <= {key_s_r[1:0], ZERO_KEY};
         din_s_r <= {din_s_r[1:0], ZERO_DIN};
         ser_s_r <= {ser_s_r[1:0], ZERO_SERIAL};
         fb_s_r <= {fb_s_r[1:0], ZERO_FIELDBUS};
         key_d_r <= key_lvl;
         din_d_r <= din_lvl;
         ser_d_r <= ser_lvl;
         fb_d_r <= fb_s_r[2];
      end
   end

   // Zero reference: power-up capture, requests, then tracking
   always @(posedge CLK_SYS) begin
      if (RST) begin
         zero_r <= {WW{1'b0}};
         init_zero_r <= {WW{1'b0}};
         pu_pend_r <= 1'b1;
         azt_cnt_r <= 32'h0;
         CENTER_ZERO <= 1'b0;
      end else begin
         CENTER_ZERO <= (net_abs <= {{(WW-1){1'b0}}, 1'b1});
         azt_cnt_r <= (azt_cnt_r >= AZT_STEP_CYC - 1) ? 32'h0 : azt_cnt_r + 32'h1;
         if (pu_pend_r && ctrl_r[`SZM_CTRL_PU_EN]) begin
            // Keeps waiting through motion; never gives up
            if (pu_ok) begin // R3
               zero_r <= GROSS_RAW;
               init_zero_r <= GROSS_RAW;
               pu_pend_r <= 1'b0;
            end
         end else begin
            if (!ctrl_r[`SZM_CTRL_PU_EN])
               pu_pend_r <= 1'b0;
            if (req_any && semi_ok) begin // R5 R13
               zero_r <= GROSS_RAW;
            end else if (ctrl_r[`SZM_CTRL_AZT_EN] && !MOTION && net != 0 &&
                         net_abs <= azt_lim && azt_cnt_r == 32'h0) begin // R1 R2
               // One division per step keeps the correction invisible
               zero_r <= net[WW-1] ? zero_r - 1'b1 : zero_r + 1'b1;
            end
         end
      end
   end

   // Timed supervision sequence
   always @(posedge CLK_SYS) begin
      if (RST) begin
         st_r <= `SZM_S_IDLE;
         tmr_r <= 32'h0;
         drop_r <= 32'h0;
         ZERO_REQ_OUT <= 1'b0;
         ZERO_REQ_MSG <= 1'b0;
         SYS_ALARM_OUT <= 1'b0;
         DATA_VALID <= 1'b1;
         ZERO_NOT_CAPTURED <= 1'b0;
         WEIGHT_BLANK <= 1'b0;
      end else begin
         if (drop_r != 32'h0) begin
            drop_r <= drop_r - 32'h1;
            if (drop_r == 32'h1)
               ZERO_REQ_OUT <= 1'b1; // R9
         end
         case (st_r)
            `SZM_S_IDLE: begin
               tmr_r <= 32'h0;
               if (ctrl_r[`SZM_CTRL_SUP_EN]) // R14
                  st_r <= `SZM_S_RUN1;
            end
            `SZM_S_RUN1, `SZM_S_RUN2, `SZM_S_RUN3: begin
               if (!ctrl_r[`SZM_CTRL_SUP_EN]) begin
                  st_r <= `SZM_S_IDLE;
                  ZERO_REQ_OUT <= 1'b0;
                  ZERO_REQ_MSG <= 1'b0;
                  drop_r <= 32'h0;
               end else if (stable_coz) begin // R7 R10
                  tmr_r <= 32'h0;
                  st_r <= `SZM_S_RUN1;
                  ZERO_REQ_OUT <= 1'b0;
                  ZERO_REQ_MSG <= 1'b0;
                  drop_r <= 32'h0;
               end else if (tmr_r >= timeout_r - 32'h1) begin // R15
                  tmr_r <= 32'h0;
                  ZERO_REQ_MSG <= 1'b1;
                  if (st_r == `SZM_S_RUN1) begin
                     ZERO_REQ_OUT <= 1'b1; // R8
                     st_r <= `SZM_S_RUN2;
                  end else begin
                     // Low for the drop period, then back high
                     ZERO_REQ_OUT <= 1'b0; // R9 R11
                     drop_r <= DROP_CYC; // R15
                     st_r <= (st_r == `SZM_S_RUN2) ? `SZM_S_RUN3 : `SZM_S_INV;
                     if (st_r == `SZM_S_RUN3) begin // R11
                        SYS_ALARM_OUT <= 1'b1;
                        DATA_VALID <= 1'b0;
                        ZERO_NOT_CAPTURED <= 1'b1;
                        WEIGHT_BLANK <= 1'b1;
                     end
                  end
               end else begin
                  tmr_r <= tmr_r + 32'h1;
               end
            end
            `SZM_S_INV: begin
               // Only a stable centre of zero leaves this state
               if (stable_coz) begin // R12
                  st_r <= ctrl_r[`SZM_CTRL_SUP_EN] ? `SZM_S_RUN1 : `SZM_S_IDLE;
                  tmr_r <= 32'h0;
                  drop_r <= 32'h0;
                  ZERO_REQ_OUT <= 1'b0;
                  ZERO_REQ_MSG <= 1'b0;
                  SYS_ALARM_OUT <= 1'b0;
                  DATA_VALID <= 1'b1;
                  ZERO_NOT_CAPTURED <= 1'b0;
                  WEIGHT_BLANK <= 1'b0;
               end
            end
            default: st_r <= `SZM_S_IDLE;
         endcase
      end
   end

   // Interrupt events
   always @* begin
      ev = {`SZM_NEV{1'b0}};
      ev[`SZM_EV_ZERO_TAKEN] = req_any & semi_ok & ~pu_pend_r;
      ev[`SZM_EV_ZERO_REJ] = req_any & ~semi_ok & ~pu_pend_r;
      ev[`SZM_EV_EXPIRY] = ctrl_r[`SZM_CTRL_SUP_EN] && !stable_coz && tmr_r >= timeout_r - 32'h1 &&
         (st_r == `SZM_S_RUN1 || st_r == `SZM_S_RUN2 || st_r == `SZM_S_RUN3);
      ev[`SZM_EV_INVALID] = ev[`SZM_EV_EXPIRY] && st_r == `SZM_S_RUN3;
      ev[`SZM_EV_VALID] = st_r == `SZM_S_INV && stable_coz;
      ev[`SZM_EV_PU_DONE] = pu_pend_r && ctrl_r[`SZM_CTRL_PU_EN] && pu_ok;
   end

   // APB writes; an event in the clearing cycle survives
   always @(posedge CLK_SYS) begin
      if (RST) begin
         ctrl_r <= `SZM_CTRL_RST;
         azt_band_r <= `SZM_AZT_BAND_RST;
         pu_hi_r <= `SZM_PU_BAND_RST;
         pu_lo_r <= `SZM_PU_BAND_RST;
         semi_band_r <= `SZM_SEMI_BAND_RST;
         timeout_r <= `SZM_TIMEOUT_RST;
         cap_r <= `SZM_CAP_RST;
         int_r <= {`SZM_NEV{1'b0}};
         mask_r <= {`SZM_NEV{1'b0}};
      end else begin
         int_r <= (int_r & ~((wr && PADDR == `SZM_INT_OFF) ? PWDATA[`SZM_NEV-1:0]
            : {`SZM_NEV{1'b0}})) | ev;
         if (wr) begin
            case (PADDR)
               `SZM_CTRL_OFF: ctrl_r <= {28'h0, PWDATA[3:0]};
               `SZM_AZT_BAND_OFF: azt_band_r <= (PWDATA > 32'd1000) ? 32'd1000 : PWDATA; // R1
               `SZM_PU_HI_OFF: pu_hi_r <= (PWDATA > 32'd100) ? 32'd100 : PWDATA; // R4
               `SZM_PU_LO_OFF: pu_lo_r <= (PWDATA > 32'd100) ? 32'd100 : PWDATA; // R4
               `SZM_SEMI_BAND_OFF: semi_band_r <= (PWDATA > 32'd100) ? 32'd100 : PWDATA; // R6
               `SZM_TIMEOUT_OFF: timeout_r <= (PWDATA == 32'h0) ? 32'h1 : PWDATA; // R15
               `SZM_CAP_OFF: cap_r <= PWDATA;
               `SZM_MASK_OFF: mask_r <= PWDATA[`SZM_NEV-1:0];
               default: ;
            endcase
         end
      end
   end

   // APB read mux, zero for unmapped
   assign rd_ok = PSEL & ~PWRITE;
   always @* begin
      PRDATA = 32'h0;
      if (rd_ok) begin
         case (PADDR)
            `SZM_CTRL_OFF: PRDATA = ctrl_r;
            `SZM_AZT_BAND_OFF: PRDATA = azt_band_r;
            `SZM_PU_HI_OFF: PRDATA = pu_hi_r;
            `SZM_PU_LO_OFF: PRDATA = pu_lo_r;
            `SZM_SEMI_BAND_OFF: PRDATA = semi_band_r;
            `SZM_TIMEOUT_OFF: PRDATA = timeout_r;
            `SZM_CAP_OFF: PRDATA = cap_r;
            `SZM_ZERO_OFF: PRDATA = {{(32-WW){zero_r[WW-1]}}, zero_r};
            `SZM_STATUS_OFF: PRDATA = {22'h0, pu_pend_r, st_r, WEIGHT_BLANK, DATA_VALID,
               SYS_ALARM_OUT, ZERO_REQ_MSG, ZERO_REQ_OUT, CENTER_ZERO};
            `SZM_INT_OFF: PRDATA = {26'h0, int_r};
            `SZM_MASK_OFF: PRDATA = {26'h0, mask_r};
            default: PRDATA = 32'h0;
         endcase
      end
   end
endmodule // szm_zero_mgmt
`default_nettype wire

// ### src/szm_defines.vh
/*
 Constants for the scale zero management block: APB register offsets,
 field positions, reset values and timing counts. Assumes a 100 MHz clock.
*/
`ifndef SZM_DEFINES_VH
`define SZM_DEFINES_VH

// Register byte offsets
`define SZM_CTRL_OFF      12'h000
`define SZM_AZT_BAND_OFF  12'h004
`define SZM_PU_HI_OFF     12'h008
`define SZM_PU_LO_OFF     12'h00c
`define SZM_SEMI_BAND_OFF 12'h010
`define SZM_TIMEOUT_OFF   12'h014
`define SZM_CAP_OFF       12'h018
`define SZM_ZERO_OFF      12'h01c
`define SZM_STATUS_OFF    12'h020
`define SZM_INT_OFF       12'h024
`define SZM_MASK_OFF      12'h028

// Control fields
`define SZM_CTRL_AZT_EN   0
`define SZM_CTRL_PU_EN    1
`define SZM_CTRL_SEMI_EN  2
`define SZM_CTRL_SUP_EN   3
`define SZM_CTRL_SW_ZERO  4
`define SZM_CTRL_RST      32'h0000_0006

// Event bits
`define SZM_EV_ZERO_TAKEN 0
`define SZM_EV_ZERO_REJ   1
`define SZM_EV_EXPIRY     2
`define SZM_EV_INVALID    3
`define SZM_EV_VALID      4
`define SZM_EV_PU_DONE    5
`define SZM_NEV           6

// Reset values of the bands and the capacity
`define SZM_AZT_BAND_RST  32'h0000_0032
`define SZM_PU_BAND_RST   32'h0000_0000
`define SZM_SEMI_BAND_RST 32'h0000_0000
`define SZM_CAP_RST       32'h0000_2710

// Timing
`define SZM_CLK_MHZ       100
`define SZM_DROP_MS       200
`define SZM_DROP_CYC      (`SZM_DROP_MS * 1000 * `SZM_CLK_MHZ)
`define SZM_TIMEOUT_RST   32'h05f5_e100
`define SZM_AZT_STEP_CYC  1000

// Supervision states
`define SZM_S_IDLE 3'h0
`define SZM_S_RUN1 3'h1
`define SZM_S_RUN2 3'h2
`define SZM_S_RUN3 3'h3
`define SZM_S_INV  3'h4

`endif

// ### verif/szm_zero_mgmt_sva.sv
/*
 Port checker for the scale zero management block.
 Assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module szm_zero_mgmt_sva #(
   parameter WW = 24
) (
   input wire CLK_SYS,
   input wire RST,
   input wire PSEL,
   input wire PREADY,
   input wire [31:0] PRDATA,
   input wire PSLVERR,
   input wire signed [WW-1:0] GROSS_RAW,
   input wire MOTION,
   input wire signed [WW-1:0] GROSS_ZEROED,
   input wire CENTER_ZERO,
   input wire ZERO_REQ_OUT,
   input wire ZERO_REQ_MSG,
   input wire SYS_ALARM_OUT,
   input wire DATA_VALID,
   input wire ZERO_NOT_CAPTURED,
   input wire WEIGHT_BLANK
);
   // Stable centre of zero as the block samples it
   wire coz_stable = CENTER_ZERO && !MOTION;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   a_apb_always_ok: assert property (PREADY && !PSLVERR)
      else $error("bus answer not zero-wait okay");
   a_prdata_idle_zero: assert property (!PSEL |-> PRDATA == 32'h0)
      else $error("read data not zero while idle");
   a_invalid_flags_agree: assert property (SYS_ALARM_OUT == WEIGHT_BLANK &&
      SYS_ALARM_OUT == ZERO_NOT_CAPTURED && DATA_VALID == !SYS_ALARM_OUT)
      else $error("invalid-state flags disagree");
   a_motion_freezes_zero: assert property (!$past(RST) && $past(MOTION) &&
      $stable(GROSS_RAW) |-> $stable(GROSS_ZEROED))
      else $error("zero moved during motion");
   a_restore_needs_coz: assert property (!$past(RST) && $fell(SYS_ALARM_OUT) |->
      $past(coz_stable) || $past(coz_stable, 2))
      else $error("alarm cleared without stable centre of zero");
   a_alarm_drops_req: assert property ($rose(SYS_ALARM_OUT) |-> ##[0:1] !ZERO_REQ_OUT)
      else $error("third expiry did not drop zero request");
   a_msg_with_req: assert property ($rose(ZERO_REQ_OUT) |-> ##[0:1] ZERO_REQ_MSG)
      else $error("zero request without message");
   a_coz_clears_req: assert property (coz_stable && ZERO_REQ_OUT |-> ##[1:2] !ZERO_REQ_OUT)
      else $error("stable centre of zero left request set");
   a_coz_restores: assert property (coz_stable && SYS_ALARM_OUT |->
      ##[1:2] (!SYS_ALARM_OUT && DATA_VALID && !ZERO_REQ_OUT))
      else $error("stable centre of zero did not restore outputs");
   c_first_expiry: cover property ($rose(ZERO_REQ_OUT));
   c_went_invalid: cover property ($rose(SYS_ALARM_OUT));
   c_restored: cover property ($fell(SYS_ALARM_OUT));
endmodule // szm_zero_mgmt_sva
bind szm_zero_mgmt szm_zero_mgmt_sva #(.WW(WW)) u_sva (.CLK_SYS(CLK_SYS), .RST(RST),
   .PSEL(PSEL), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .GROSS_RAW(GROSS_RAW), .MOTION(MOTION), .GROSS_ZEROED(GROSS_ZEROED),
   .CENTER_ZERO(CENTER_ZERO), .ZERO_REQ_OUT(ZERO_REQ_OUT), .ZERO_REQ_MSG(ZERO_REQ_MSG),
   .SYS_ALARM_OUT(SYS_ALARM_OUT), .DATA_VALID(DATA_VALID),
   .ZERO_NOT_CAPTURED(ZERO_NOT_CAPTURED), .WEIGHT_BLANK(WEIGHT_BLANK));
`default_nettype wire

// ### verif/szm_scale_model.sv
/*
 Model of the weighing path and the four zero command sources.
 Assumes the bench calls its tasks; all pins change after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module szm_scale_model #(
   parameter WW = 24
) (
   input wire logic clk,
   output logic signed [WW-1:0] gross,
   output logic motion,
   output logic [3:0] req
);
   // Scale starts loaded and moving so no capture happens early
   initial begin
      gross = 40;
      motion = 1'h1;
      req = 4'h0;
   end
   task set_load(input logic signed [WW-1:0] w, input logic m);
      @(posedge clk);
      gross <= w;
      motion <= m;
   endtask
   // Held four cycles so the input synchroniser sees one clean edge
   task press(input int idx);
      @(posedge clk);
      req[idx] <= 1'h1;
      repeat (4) @(posedge clk);
      req[idx] <= 1'h0;
   endtask
endmodule // szm_scale_model
`default_nettype wire

// ### verif/test_scale_zero_management.sv
/*
 Self-checking bench for the scale zero management block.
 Assumes the block is run with short drop and tracking step counts.
*/
`timescale 1ns/10ps
`default_nettype none
`include "szm_defines.vh"
module test_scale_zero_management;
   logic clk_sys, rst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdata;
   wire pready, pslverr, motion, coz, zreq, zmsg, alarm, valid, nocap, blank, irq;
   wire [31:0] prdata;
   wire signed [23:0] gross, zeroed;
   wire [3:0] req;
   int bad_count, comparisons, cycles, n, i;
   // Clock at 100 MHz
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Both sides keep their default width of 24 divisions bits
   szm_scale_model u_scale (.clk(clk_sys), .gross(gross), .motion(motion), .req(req));
   szm_zero_mgmt #(.DROP_CYC(50), .AZT_STEP_CYC(4)) DUT (.CLK_SYS(clk_sys),
      .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .GROSS_RAW(gross), .MOTION(motion), .ZERO_KEY(req[0]), .ZERO_DIN(req[1]),
      .ZERO_SERIAL(req[2]), .ZERO_FIELDBUS(req[3]), .GROSS_ZEROED(zeroed),
      .CENTER_ZERO(coz), .ZERO_REQ_OUT(zreq), .ZERO_REQ_MSG(zmsg), .SYS_ALARM_OUT(alarm),
      .DATA_VALID(valid), .ZERO_NOT_CAPTURED(nocap), .WEIGHT_BLANK(blank), .IRQ(irq));
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One bus transfer; held until ready is seen at a rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      @(posedge clk_sys);
      while (pready !== 1'h1) @(posedge clk_sys);
      rdata = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'h0, a, 32'h0);
      chk(rdata, exp, what);
   endtask
   task gap(input int c);
      repeat (c) @(negedge clk_sys);
   endtask
   task wait_req(input logic v);
      n = 0;
      while (zreq !== v && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   // Length of one low stretch of the zero request
   task drop_len;
      wait_req(1'h0);
      wait_req(1'h1);
   endtask
   task t_reset;
      rd(`SZM_CTRL_OFF, `SZM_CTRL_RST, "ctrl reset");
      rd(`SZM_AZT_BAND_OFF, `SZM_AZT_BAND_RST, "track band reset");
      rd(`SZM_TIMEOUT_OFF, `SZM_TIMEOUT_RST, "timeout reset");
      apb(1'h1, 12'h030, 32'hffff_ffff);
      rd(12'h030, 32'h0, "unmapped read");
      chk(valid, 1'h1, "valid after reset");
      $display("test reset done");
   endtask
   task t_powerup;
      apb(1'h1, `SZM_PU_HI_OFF, 32'h64);
      apb(1'h1, `SZM_PU_LO_OFF, 32'h64);
      gap(10);
      rd(`SZM_ZERO_OFF, 32'h0, "no capture in motion");
      u_scale.set_load(40, 1'h0);
      gap(20);
      chk(zeroed, 0, "power-up zero");
      rd(`SZM_ZERO_OFF, 32'h28, "captured reference");
      chk(irq, 1'h0, "masked event");
      apb(1'h1, `SZM_MASK_OFF, 32'h20);
      gap(1);
      chk(irq, 1'h1, "unmasked event");
      apb(1'h1, `SZM_INT_OFF, 32'h3f);
      gap(1);
      chk(irq, 1'h0, "event cleared");
      apb(1'h1, `SZM_MASK_OFF, 32'h0);
      $display("test power-up done");
   endtask
   task t_request;
      u_scale.set_load(60, 1'h0);
      apb(1'h1, `SZM_CTRL_OFF, 32'h2);
      u_scale.press(0);
      gap(10);
      chk(zeroed, 20, "request while disabled");
      apb(1'h1, `SZM_SEMI_BAND_OFF, 32'h64);
      apb(1'h1, `SZM_CTRL_OFF, 32'h6);
      for (i = 0; i < 4; i++) begin
         u_scale.set_load(70 + 10 * i, 1'h0);
         u_scale.press(i);
         gap(10);
         chk(zeroed, 0, "request from each source");
      end
      // Software zero strobe; the control word keeps only its low four bits
      u_scale.set_load(95, 1'h0);
      apb(1'h1, `SZM_CTRL_OFF, 32'h16);
      gap(2);
      chk(zeroed, 0, "software zero request");
      rd(`SZM_CTRL_OFF, 32'h6, "zero strobe not stored");
      apb(1'h1, `SZM_SEMI_BAND_OFF, 32'h0);
      u_scale.set_load(105, 1'h0);
      u_scale.press(0);
      gap(10);
      chk(zeroed, 10, "request outside band");
      $display("test request done");
   endtask
   task t_azt;
      apb(1'h1, `SZM_CTRL_OFF, 32'h7);
      u_scale.set_load(103, 1'h0);
      gap(40);
      chk(zeroed, 0, "tracked to centre");
      u_scale.set_load(163, 1'h0);
      gap(40);
      chk(zeroed, 60, "no tracking outside band");
      apb(1'h1, `SZM_CTRL_OFF, 32'h6);
      $display("test tracking done");
   endtask
   // Expiry sequence, invalid state, restore and timer restarts
   task t_super;
      u_scale.set_load(123, 1'h0);
      apb(1'h1, `SZM_TIMEOUT_OFF, 32'hc8);
      apb(1'h1, `SZM_MASK_OFF, 32'h4);
      apb(1'h1, `SZM_CTRL_OFF, 32'he);
      wait_req(1'h1);
      chk(zmsg, 1'h1, "first expiry message");
      chk(irq, 1'h1, "expiry event");
      drop_len;
      chk(n, 50, "second expiry drop");
      chk(alarm, 1'h0, "no alarm yet");
      drop_len;
      chk(n, 50, "third expiry drop");
      chk({alarm, valid, blank, nocap}, 4'hb, "invalid state");
      u_scale.set_load(103, 1'h0);
      gap(5);
      chk({alarm, valid, zreq}, 3'h2, "restored");
      u_scale.set_load(123, 1'h0);
      wait_req(1'h1);
      u_scale.set_load(103, 1'h0);
      gap(5);
      chk(zreq, 1'h0, "pending request cleared");
      u_scale.set_load(123, 1'h0);
      gap(150);
      u_scale.set_load(103, 1'h0);
      gap(5);
      u_scale.set_load(123, 1'h0);
      gap(150);
      chk(zreq, 1'h0, "timer restarted at centre");
      apb(1'h1, `SZM_INT_OFF, 32'h3f);
      $display("test supervision done");
   endtask
   // Watchdog on a hung run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         $display("[FAIL] %0t watchdog expired", $time);
         final_report;
      end
   end
   // Main sequence
   initial begin
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'h0;
      t_reset;
      t_powerup;
      t_request;
      t_azt;
      t_super;
      final_report;
   end
endmodule // test_scale_zero_management
`default_nettype wire
